/* dv/nvm_seq_props.sv */
// checker for the sequencer: apb handshake, stall length and busy refusals
// assumes a zero-wait apb slave and a 50 us stall at 8 ns
`timescale 1ns/1ps
module nvm_seq_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire external_reset_pin,
  input wire watchdog_timer,
  input wire cpu_stall
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  logic [12:0] cnt;
  logic ab;
  logic [2:0] lw;
  // soft reset may cut a stall short, so such stalls skip the length check
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 13'h0;
      ab <= 1'b0;
      lw <= 3'h0;
    end else begin
      cnt <= cpu_stall ? cnt + 13'h1 : 13'h0;
      ab <= (external_reset_pin || watchdog_timer) ? 1'b1 : (cpu_stall && ab);
      lw <= {lw[1:0], setup && pwrite && paddr == 12'h004 && pwdata[0]};
    end
  end
  AST_READY_ONE: assert property (pready |=> !pready) else $error("pready held too long");
  AST_READY_AFTER_SETUP: assert property (setup |=> pready) else $error("no pready after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("stray pready");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property (setup && paddr > 12'h018 |=> pslverr)
    else $error("unmapped access not flagged");
  AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> lw != 3'h0)
    else $error("stall without launch write");
  AST_STALL_LENGTH: assert property ($fell(cpu_stall) && !ab |-> cnt >= 13'd6249 && cnt <= 13'd6253)
    else $error("stall length wrong");
  AST_BUSY_CTRL1_REFUSED: assert property (cpu_stall && setup && pwrite && paddr == 12'h004 |=> pslverr)
    else $error("control write taken while busy");
  AST_READ_DATA_HOLDS: assert property (!(psel && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read");
  cover property ($fell(cpu_stall));
  cover property (pslverr);
  cover property (setup && !pwrite && paddr == 12'h010);
endmodule
bind nvm_write_read_sequencer nvm_seq_props nvm_seq_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset_pin(external_reset_pin),
  .watchdog_timer(watchdog_timer), .cpu_stall(cpu_stall));

/* dv/test_nvm_write_read_sequencer.sv */
// self-checking bench: apb master, byte array model, refusals, stall and soft reset
// assumes the zero-wait apb slave of the sequencer with short power-up and byte timers
`timescale 1ns/1ps
`include "nvm_seq_defs.vh"
module test_nvm_write_read_sequencer;
  logic pclk, presetn, psel, penable, pwrite, external_reset_pin, watchdog_timer;
  logic data_write_protect, pready, pslverr, cpu_stall, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0;
  int comparisons = 0;
  int model[int];
  int a, v, i;
  nvm_write_read_sequencer #(.PWRT_CYCLES(4), .BYTE_CYCLES(10)) nvm_write_read_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin(external_reset_pin), .watchdog_timer(watchdog_timer),
    .data_write_protect(data_write_protect), .cpu_stall(cpu_stall));
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // stalled word writes take about 6250 cycles, hence the long bound
  task automatic poll(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      apb(0, ad, 0);
      n++;
    end while ((rd & m) !== want && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task automatic wbyte(input int ad, input int d, input logic [7:0] k1);
    apb(1, `OFF_ADDR, ad);
    apb(1, `OFF_DATA, d);
    apb(1, `OFF_KEY, {24'h0, k1});
    apb(1, `OFF_KEY, {24'h0, `KEY_WORD_B});
    apb(1, `OFF_CTRL1, 32'h1);
  endtask
  task automatic rdbyte;
    apb(1, `OFF_CTRL0, 32'h1);
    apb(1, `OFF_CTRL0, 32'h9);
    apb(0, `OFF_DATA, 0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {external_reset_pin, watchdog_timer, data_write_protect} = 0;
    v = $urandom(66498);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    poll(`OFF_STAT, 2, 0);
    apb(1, `OFF_CTRL0, 32'h1);
    for (i = 0; i < 4; i++) begin
      a = `DATA_BASE + ($urandom % `DATA_WORDS);
      model[a] = $urandom % 256;
      wbyte(a, model[a], `KEY_WORD_A);
      poll(`OFF_CTRL0, 4, 4);
      chk("gate", rd & 1, 1);
      rdbyte;
      chk("byte", rd & 255, model[a]);
    end
    $display("test byte write done");
    for (i = 0; i < 4; i++) begin
      apb(1, `OFF_DATA, model[a] ^ 255);
      if (i == 1) apb(1, `OFF_CTRL0, 0);
      if (i != 3) apb(1, `OFF_KEY, i == 0 ? 32'h54 : 32'h55);
      if (i == 2) apb(1, `OFF_ADDR, a);
      if (i != 3) apb(1, `OFF_KEY, 32'hAA);
      apb(1, `OFF_CTRL1, 32'h1);
      apb(0, `OFF_STAT, 0);
      chk("busy", rd & 1, 0);
      rdbyte;
      chk("kept", rd & 255, model[a]);
    end
    $display("test refusals done");
    data_write_protect <= 1;
    wbyte(a, model[a] ^ 255, `KEY_WORD_A);
    poll(`OFF_CTRL0, 2, 2);
    data_write_protect <= 0;
    apb(0, 12'h020, 0);
    chk("unmapped", er, 1);
    $display("test protect done");
    apb(1, `OFF_CTRL0, 32'h1);
    wbyte(32'h100, $urandom % 65536, `KEY_WORD_A);
    chk("stall", cpu_stall, 1);
    apb(1, `OFF_CTRL1, 32'h1);
    chk("busy err", er, 1);
    poll(`OFF_STAT, 1, 0);
    chk("stall end", cpu_stall, 0);
    $display("test word write done");
    for (i = 0; i < 2; i++) begin
      apb(1, `OFF_CTRL0, 32'h1);
      wbyte(a, 8'h3C, `KEY_WORD_A);
      if (i == 0) external_reset_pin <= 1;
      else watchdog_timer <= 1;
      repeat (3) @(posedge pclk);
      {external_reset_pin, watchdog_timer} <= 2'b00;
      // the synchronised reset lingers two edges after the pins drop
      repeat (3) @(posedge pclk);
      apb(0, `OFF_CTRL0, 0);
      chk("abort", rd & 3, 2);
    end
    $display("test soft reset done");
    tally_and_finish;
  end
endmodule

/* hdl/nvm_seq_defs.vh */
// constants for the nonvolatile memory write/read sequencer
// assumes inclusion by bare name from design files
`ifndef NVM_SEQ_DEFS_VH
`define NVM_SEQ_DEFS_VH
`define OFF_CTRL0 12'h000
`define OFF_CTRL1 12'h004
`define OFF_KEY 12'h008
`define OFF_ADDR 12'h00C
`define OFF_DATA 12'h010
`define OFF_PROT 12'h014
`define OFF_STAT 12'h018
`define C0_GATE 0
`define C0_FAULT 1
`define C0_DONE 2
`define C0_READ 3
`define C1_WR 0
`define C1_SECTOR_WRITE_LAUNCH 1
`define C1_SECTOR_READ_LAUNCH 2
`define C1_SECTOR_ERASE_LAUNCH 3
`define KEY_WORD_A 8'h55
`define KEY_WORD_B 8'hAA
`define KEY_SECTOR_WRITE_LAUNCH_A 8'hDD
`define KEY_SECTOR_WRITE_LAUNCH_B 8'h22
`define KEY_SECTOR_ERASE_LAUNCH_A 8'hCC
`define KEY_SECTOR_ERASE_LAUNCH_B 8'h33
`define ADDR_W 22
`define CODE_TOP 22'h01_FFFF
`define UID_BASE 22'h20_0000
`define UID_TOP 22'h20_003F
`define CFG_BASE 22'h30_0000
`define CFG_TOP 22'h30_000B
`define DATA_BASE 22'h31_0000
`define DATA_TOP 22'h31_03FF
`define ID_BASE 22'h3F_FFFC
`define DATA_WORDS 1024
`define WORD_WRITE_NS 50000
`define BYTE_WRITE_NS 4000
`define PWRT_NS 65536000
`define CLK_NS 8
`define PROT_W 4
`endif

/* hdl/nvm_write_read_sequencer.v */
// nonvolatile memory write/read sequencer: apb registers, unlock tracking, timed writes
// assumes a single processor master on apb at pclk; code array modelled by a stall timer
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "nvm_seq_defs.vh"
module nvm_write_read_sequencer #(
  parameter PWRT_CYCLES = (`PWRT_NS + `CLK_NS - 1) / `CLK_NS,
  parameter BYTE_CYCLES = `BYTE_WRITE_NS / `CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_reset_pin,
  input wire watchdog_timer,
  input wire data_write_protect,
  output reg cpu_stall
);
  localparam WORD_CYCLES = `WORD_WRITE_NS / `CLK_NS;
  localparam ST_IDLE = 3'b001;
  localparam ST_CODE = 3'b010;
  localparam ST_DATA = 3'b100;
  localparam [1:0] K_NONE = 2'b00;
  localparam [1:0] K_FIRST = 2'b01;
  localparam [1:0] K_OPEN = 2'b10;

  reg [2:0] state;
  reg access_gate;
  reg operation_fault_flag;
  reg completion_event_flag;
  reg write_launch;
  reg [`ADDR_W-1:0] target_location_pointer;
  reg [15:0] transfer_data_word;
  reg [1:0] key_state;
  reg [7:0] key_first;
  reg [7:0] key_second;
  reg [31:0] timer;
  reg [31:0] pwrt_count;
  wire [`PROT_W-1:0] code_protect;
  reg [7:0] data_mem [0:`DATA_WORDS-1];
  reg [15:0] word_latch;
  reg rst_s1;
  reg rst_s2;
  reg wdt_s1;
  reg wdt_s2;
  reg [31:0] next_prdata;
  reg mapped;
  reg start_data;
  reg start_code;
  reg launch_fault;
  reg cfg_write;

  wire busy = (state != ST_IDLE);
  wire setup = psel & ~penable;
  wire wr_acc = setup & pwrite;
  wire in_code = (target_location_pointer <= `CODE_TOP);
  wire in_uid = (target_location_pointer >= `UID_BASE) && (target_location_pointer <= `UID_TOP);
  wire in_cfg = (target_location_pointer >= `CFG_BASE) && (target_location_pointer <= `CFG_TOP);
  wire in_data = (target_location_pointer >= `DATA_BASE) &&
                 (target_location_pointer <= `DATA_TOP);
  wire in_id = (target_location_pointer >= `ID_BASE);
  wire [9:0] data_idx = target_location_pointer[9:0];
  wire word_key = (key_first == `KEY_WORD_A) && (key_second == `KEY_WORD_B);
  wire sector_write_launch_key = (key_first == `KEY_SECTOR_WRITE_LAUNCH_A) && (key_second == `KEY_SECTOR_WRITE_LAUNCH_B);
  wire sector_erase_launch_key = (key_first == `KEY_SECTOR_ERASE_LAUNCH_A) && (key_second == `KEY_SECTOR_ERASE_LAUNCH_B);
  wire unlocked = (key_state == K_OPEN);
  wire pwrt_run = (pwrt_count != 32'h0000_0000);
  wire ctrl1_wr = wr_acc && (paddr == `OFF_CTRL1) && !busy;
  wire ctrl0_wr = wr_acc && (paddr == `OFF_CTRL0) && !busy;
  wire key_wr = wr_acc && (paddr == `OFF_KEY);

  // pin-level reset causes, synchronised before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
    end else begin
      rst_s1 <= external_reset_pin;
      rst_s2 <= rst_s1;
      wdt_s1 <= watchdog_timer;
      wdt_s2 <= wdt_s1;
    end
  end

  // fault survives the pin resets, which abort the write in progress
  wire soft_reset = rst_s2 | wdt_s2;

  // key tracking: only back-to-back writes to the key port count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state <= K_NONE;
      key_first <= 8'h00;
      key_second <= 8'h00;
    end else if (soft_reset) begin
      key_state <= K_NONE;
    end else if (key_wr) begin
      if (key_state == K_NONE || key_state == K_OPEN) begin
        key_first <= pwdata[7:0];
        key_state <= K_FIRST;
      end else begin
        key_second <= pwdata[7:0];
        key_state <= K_OPEN;
      end
    end else if (wr_acc) begin
      key_state <= K_NONE;
    end
  end

  // read mux; the key port reads back as zero so keys never leak
  always @* begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `OFF_CTRL0) begin
      next_prdata[3:0] = {1'b0, completion_event_flag, operation_fault_flag, access_gate};
    end else if (paddr == `OFF_CTRL1) begin
      next_prdata[0] = write_launch;
    end else if (paddr == `OFF_ADDR) begin
      next_prdata[`ADDR_W-1:0] = target_location_pointer;
    end else if (paddr == `OFF_DATA) begin
      next_prdata[15:0] = transfer_data_word;
    end else if (paddr == `OFF_PROT) begin
      next_prdata[`PROT_W-1:0] = code_protect;
    end else if (paddr == `OFF_STAT) begin
      next_prdata[1:0] = {pwrt_run, busy};
    end else if (paddr != `OFF_KEY) begin
      mapped = 1'b0;
    end
  end

  // zero-wait slave: answer one cycle after setup; a soft reset swallows the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (soft_reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= (setup && !mapped) || (wr_acc && paddr == `OFF_CTRL1 && busy);
      if (setup && !pwrite)
        prdata <= next_prdata;
    end
  end

  // launch decode; every start needs the gate, the matching key pair and a valid target
  always @* begin
    start_data = 1'b0;
    start_code = 1'b0;
    launch_fault = 1'b0;
    cfg_write = 1'b0;
    if (ctrl1_wr && access_gate) begin
      if (pwdata[`C1_WR] && unlocked && word_key) begin
        if ((in_data && (data_write_protect || pwrt_run)) || in_cfg || in_id ||
            !(in_code || in_uid || in_data))
          launch_fault = 1'b1;
        else if (in_data)
          start_data = 1'b1;
        else
          start_code = 1'b1;
      end else if (pwdata[`C1_SECTOR_WRITE_LAUNCH] && unlocked && sector_write_launch_key) begin
        if (in_cfg)
          cfg_write = 1'b1;
        else
          launch_fault = in_data | in_id;
      end else if (pwdata[`C1_SECTOR_ERASE_LAUNCH] && unlocked && sector_erase_launch_key) begin
        launch_fault = in_cfg | in_data | in_id;
      end else if (pwdata[`C1_SECTOR_READ_LAUNCH] && in_data) begin
        launch_fault = 1'b1;
      end
    end
  end

  // only software moves the gate, except that any reset closes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      access_gate <= 1'b0;
    else if (soft_reset)
      access_gate <= 1'b0;
    else if (ctrl0_wr)
      access_gate <= pwdata[`C0_GATE];
  end

  // software clears a flag by writing zero to it; a hardware set comes later and wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_fault_flag <= 1'b0;
      completion_event_flag <= 1'b0;
    end else begin
      if (ctrl0_wr && !soft_reset && !pwdata[`C0_FAULT])
        operation_fault_flag <= 1'b0;
      if (ctrl0_wr && !soft_reset && !pwdata[`C0_DONE])
        completion_event_flag <= 1'b0;
      if ((soft_reset && busy) || (!soft_reset && launch_fault))
        operation_fault_flag <= 1'b1;
      if (!soft_reset && state == ST_DATA && timer == 32'h0000_0000)
        completion_event_flag <= 1'b1;
    end
  end

  // write sequencer: address and data latches, launch, stall and write timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      write_launch <= 1'b0;
      target_location_pointer <= {`ADDR_W{1'b0}};
      transfer_data_word <= 16'h0000;
      timer <= 32'h0000_0000;
      pwrt_count <= PWRT_CYCLES;
      word_latch <= 16'h0000;
      cpu_stall <= 1'b0;
    end else if (soft_reset) begin
      state <= ST_IDLE;
      write_launch <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      if (pwrt_run)
        pwrt_count <= pwrt_count - 32'h0000_0001;
      if (wr_acc && !busy && paddr == `OFF_ADDR)
        target_location_pointer <= pwdata[`ADDR_W-1:0];
      if (wr_acc && !busy && paddr == `OFF_DATA)
        transfer_data_word <= pwdata[15:0];
      // the read uses the gate as it stood before this same control write
      if (ctrl0_wr && pwdata[`C0_READ] && access_gate) begin
        if (in_data)
          transfer_data_word <= {8'h00, data_mem[data_idx]};
        else
          transfer_data_word <= 16'hFFFF;
      end
      if (start_data) begin
        write_launch <= 1'b1;
        timer <= BYTE_CYCLES;
        state <= ST_DATA;
      end
      if (start_code) begin
        write_launch <= 1'b1;
        word_latch <= transfer_data_word;
        timer <= WORD_CYCLES;
        cpu_stall <= 1'b1;
        state <= ST_CODE;
      end
      if (busy) begin
        if (timer != 32'h0000_0000) begin
          timer <= timer - 32'h0000_0001;
        end else begin
          write_launch <= 1'b0;
          cpu_stall <= 1'b0;
          state <= ST_IDLE;
        end
      end
    end
  end

  // protection bits only go from clear to set, one flop per bit
  genvar g;
  generate
    for (g = 0; g < `PROT_W; g = g + 1) begin : prot_bit
      reg held;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          held <= 1'b0;
        else if (!soft_reset && cfg_write && transfer_data_word[g])
          held <= 1'b1;
      end
      assign code_protect[g] = held;
    end
  endgenerate

  // erase-before-write is implicit: the byte is simply replaced
  always @(posedge pclk) begin
    if (presetn && !soft_reset && state == ST_DATA && timer == 32'h0000_0000)
      data_mem[data_idx] <= transfer_data_word[7:0];
  end
endmodule
